// file: stc_cfg.svh
// Offsets, field positions and reset values of the transmit control block.
// Assumes a 32-bit APB register window, one register per aligned word.
`ifndef STC_CFG_SVH
`define STC_CFG_SVH

// Register byte offsets
`define STC_OFF_TXCTL 8'h00
`define STC_OFF_TXDATA 8'h04
`define STC_OFF_RXCTL 8'h08
`define STC_OFF_BAUD 8'h0C
`define STC_OFF_STAT 8'h10
`define STC_OFF_MASK 8'h14

// Fields of transmit_status_control
`define STC_B_CLKSRC 7
`define STC_B_NINE 6
`define STC_B_TX_ON 5
`define STC_B_SYNC 4
`define STC_B_BREAK 3
`define STC_B_HIGH 2
`define STC_B_EMPTY 1
`define STC_B_NINTH 0

// Fields of the receiver tie-in register
`define STC_B_RX_ONE 0
`define STC_B_RX_CONT 1

// Fields of status and mask
`define STC_B_EV_DONE 0
`define STC_B_EV_BRK 1

// Reset values
`define STC_RST_TXCTL 8'h00
`define STC_RST_BAUD 16'h0000
`define STC_RST_MASK 2'h0

// Oversampling per bit in asynchronous mode
`define STC_OVS_LOW 4'hF
`define STC_OVS_HIGH 4'h3

// Frame lengths in bits, less one
`define STC_LEN_BRK 4'hD
`define STC_LEN_A9 4'hA
`define STC_LEN_A8 4'h9
`define STC_LEN_S9 4'h8
`define STC_LEN_S8 4'h7

`endif

// file: stc_pkg.sv
// Types shared by the transmit control block.
// Assumes stc_cfg.svh is on the include path.
package stc_pkg;

typedef enum logic {ST_IDLE, ST_RUN} stc_sh_state_t;

typedef struct packed {
    stc_sh_state_t st;
    logic [12:0] sh;
    logic [3:0] cnt;
    logic tx;
    logic sck;
    logic brk;
    logic done;
    logic done_brk;
} stc_shift_st_t;

typedef struct packed {
    logic [15:0] pre;
    logic [3:0] ovs;
    logic bit_en;
} stc_baud_st_t;

typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] hold;
    logic pend;
    logic [1:0] rxctl;
    logic [15:0] div;
    logic [1:0] stat;
    logic [1:0] mask;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic irq;
    logic sck_q;
    logic tx_oe;
    logic sck_oe;
} stc_top_st_t;

endpackage

// file: stc_if.sv
// Control and status link between the register block and the shifter.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface stc_if;
    logic en;
    logic start;
    logic brk;
    logic sync;
    logic master;
    logic nine;
    logic ninth;
    logic [7:0] data;
    logic bit_en;
    logic sck_fall;
    logic busy;
    logic done;
    logic done_brk;

    modport ctrl (
        output en, start, brk, sync, master, nine, ninth, data,
        output bit_en, sck_fall,
        input busy, done, done_brk
    );
    modport shf (
        input en, start, brk, sync, master, nine, ninth, data,
        input bit_en, sck_fall,
        output busy, done, done_brk
    );
endinterface
`default_nettype wire

// file: stc_baud.sv
// Bit-rate enable generator: divisor prescaler then oversampling count.
// Assumes a single clock; the output is a one-cycle enable pulse.
`timescale 1ns/1ps
`default_nettype none
`include "stc_cfg.svh"
module stc_baud
    import stc_pkg::*;
#(
    parameter int DIV_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic [DIV_W-1:0] div_i,
    input wire logic sync_i,
    input wire logic high_i,
    output logic bit_en_o
);
    stc_baud_st_t s, n;
    logic [3:0] ovs_top;

    // Sync mode uses one tick per half clock; high speed only in async
    always_comb begin
        ovs_top = sync_i ? 4'h0 : (high_i ? `STC_OVS_HIGH : `STC_OVS_LOW);
        n = s;
        n.bit_en = 1'b0;
        if (!en_i) begin
            n.pre = '0;
            n.ovs = '0;
        end else if (s.pre >= 16'(div_i)) begin
            n.pre = '0;
            if (s.ovs >= ovs_top) begin
                n.ovs = '0;
                n.bit_en = 1'b1;
            end else begin
                n.ovs = s.ovs + 4'h1;
            end
        end else begin
            n.pre = s.pre + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign bit_en_o = s.bit_en;
endmodule
`default_nettype wire

// file: stc_shift.sv
// Transmit shifter: async frames with start and stop, breaks, and
// clocked sync frames as clock master or slave.
// Assumes bit_en and sck_fall are single-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
`include "stc_cfg.svh"
module stc_shift
    import stc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    stc_if.shf bus,
    output logic tx_o,
    output logic sck_o,
    output logic sck_oe_o
);
    stc_shift_st_t s, n;
    logic [13:0] frame;
    logic [3:0] len;
    logic adv;

    // Frame image, LSB first on the line
    always_comb begin
        if (bus.sync) begin
            frame = {5'h00, bus.ninth, bus.data};
            len = bus.nine ? `STC_LEN_S9 : `STC_LEN_S8;
        end else if (bus.brk) begin
            frame = 14'h2000;
            len = `STC_LEN_BRK;
        end else if (bus.nine) begin
            frame = {4'hF, bus.ninth, bus.data, 1'b0};
            len = `STC_LEN_A9;
        end else begin
            frame = {4'hF, 1'b1, bus.data, 1'b0};
            len = `STC_LEN_A8;
        end
    end

    // Master shifts on its own falling clock; slave on the outside one
    always_comb begin
        if (!bus.sync) begin
            adv = bus.bit_en;
        end else if (bus.master) begin
            adv = bus.bit_en & s.sck;
        end else begin
            adv = bus.sck_fall;
        end
    end

    always_comb begin
        n = s;
        n.done = 1'b0;
        n.done_brk = 1'b0;
        if (!bus.en) begin
            // Disabling aborts a frame and idles the line
            n.st = ST_IDLE;
            n.tx = 1'b1;
            n.sck = 1'b0;
        end else begin
            unique case (s.st)
                ST_IDLE: begin
                    n.sck = 1'b0;
                    if (bus.start) begin
                        n.st = ST_RUN;
                        n.sh = frame[13:1];
                        n.tx = frame[0];
                        n.cnt = len;
                        n.brk = bus.brk & ~bus.sync;
                    end
                end
                ST_RUN: begin
                    if (bus.sync && bus.master && bus.bit_en) begin
                        n.sck = ~s.sck;
                    end
                    if (adv) begin
                        if (s.cnt == 4'h0) begin
                            n.st = ST_IDLE;
                            n.tx = 1'b1;
                            n.done = 1'b1;
                            n.done_brk = s.brk;
                        end else begin
                            n.tx = s.sh[0];
                            n.sh = {1'b1, s.sh[12:1]};
                            n.cnt = s.cnt - 4'h1;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s <= '{st: ST_IDLE, sh: '0, cnt: '0, tx: 1'b1, sck: 1'b0,
                   brk: 1'b0, done: 1'b0, done_brk: 1'b0};
        end else begin
            s <= n;
        end
    end

    assign bus.busy = (s.st == ST_RUN);
    assign bus.done = s.done;
    assign bus.done_brk = s.done_brk;
    assign tx_o = s.tx;
    assign sck_o = s.sck;
    // The top owns the clock pin enable; this one stays low
    assign sck_oe_o = 1'b0;
endmodule
`default_nettype wire

// file: stc_top.sv
// Transmit control and status block with APB register access.
// Assumes APB master per the usual protocol and synchronous line inputs.
//
// Overview of operation
// - In sync mode clock_source_select set makes the port clock master from the baud generator, clear makes it a slave; ignored in async mode.
// - nine_bit_transmit_select picks 9-bit characters when one and 8-bit characters when zero.
// - The transmitter runs only while transmit_enable_bit is one; clearing it stops transmission.
// - In sync mode an active single or continuous receive enable overrides transmit_enable_bit.
// - link_mode_select one means synchronous operation, zero asynchronous.
// - In async mode break_send_request turns the next transmission into a break and hardware clears it when the break ends; ignored in sync mode.
// - In async mode high_baud_select chooses high speed when one, low speed when zero; no effect in sync mode.
// - shift_register_empty reads one while the shift register is empty, zero while full, is read-only and resets to one.
// - ninth_transmit_bit is the ninth data bit of 9-bit frames, usable as address marker or parity.
// - The baud divisor may be adjusted as the coarser alternative correction, for example by auto-baud logic.
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "stc_cfg.svh"
module stc_top
    import stc_pkg::*;
#(
    parameter int DIV_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe_o,
    output logic tx_o,
    output logic tx_oe_o,
    output logic irq_o
);
    stc_top_st_t s, n;
    stc_if lnk ();
    logic sync_m;
    logic rx_act;
    logic en_eff;
    logic wr;
    logic rd;
    logic hit;
    logic [31:0] rdat;
    logic [1:0] ev;
    logic [1:0] clr;
    logic [7:0] ctl_view;
    logic sh_tx;
    logic sh_sck;

    // Mode decode from the control register
    assign sync_m = s.ctl[`STC_B_SYNC];
    assign rx_act = s.rxctl[`STC_B_RX_ONE] | s.rxctl[`STC_B_RX_CONT];
    // Reception wins over transmission only in sync mode
    assign en_eff = s.ctl[`STC_B_TX_ON] & ~(sync_m & rx_act);

    // Controls toward the shifter
    assign lnk.en = en_eff;
    assign lnk.sync = sync_m;
    assign lnk.master = s.ctl[`STC_B_CLKSRC];
    assign lnk.nine = s.ctl[`STC_B_NINE];
    assign lnk.ninth = s.ctl[`STC_B_NINTH];
    assign lnk.brk = s.ctl[`STC_B_BREAK] & ~sync_m;
    assign lnk.data = s.hold;
    assign lnk.start = s.pend & en_eff & ~lnk.busy;
    // Slave clock edge; the input is already synchronous
    assign lnk.sck_fall = s.sck_q & ~sck_i;

    // Bit timing: high speed select only matters in async mode
    stc_baud #(
        .DIV_W(DIV_W)
    ) u_baud (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .en_i(en_eff & lnk.busy),
        .div_i(s.div[DIV_W-1:0]),
        .sync_i(sync_m),
        .high_i(s.ctl[`STC_B_HIGH]),
        .bit_en_o(lnk.bit_en)
    );

    stc_shift u_shift (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .bus(lnk),
        .tx_o(sh_tx),
        .sck_o(sh_sck),
        .sck_oe_o()
    );

    // APB access phase; the answer comes one cycle into it
    assign wr = psel_i & penable_i & s.pready & pwrite_i;
    assign rd = psel_i & penable_i & ~s.pready & ~pwrite_i;

    // Live view of the control register with the empty flag
    always_comb begin
        ctl_view = s.ctl;
        ctl_view[`STC_B_EMPTY] = ~lnk.busy;
    end

    // Read mux and address decode
    always_comb begin
        rdat = 32'h0000_0000;
        hit = 1'b1;
        unique case (paddr_i)
            `STC_OFF_TXCTL: rdat = {24'h000000, ctl_view};
            `STC_OFF_TXDATA: rdat = {24'h000000, s.hold};
            `STC_OFF_RXCTL: rdat = {30'h0, s.rxctl};
            `STC_OFF_BAUD: rdat = {16'h0000, s.div};
            `STC_OFF_STAT: rdat = {30'h0, s.stat};
            `STC_OFF_MASK: rdat = {30'h0, s.mask};
            default: hit = 1'b0;
        endcase
    end

    // Events and write-one-to-clear mask
    assign ev[`STC_B_EV_DONE] = lnk.done;
    assign ev[`STC_B_EV_BRK] = lnk.done_brk;
    assign clr = (wr && paddr_i == `STC_OFF_STAT) ? pwdata_i[1:0] : 2'h0;

    always_comb begin
        n = s;
        n.sck_q = sck_i;
        // Slave answers in the second access cycle, then drops pready
        n.pready = psel_i & penable_i & ~s.pready;
        n.pslverr = psel_i & penable_i & ~s.pready & ~hit;
        if (rd) begin
            n.prdata = rdat;
        end
        // A queued character is consumed when the shifter takes it
        if (lnk.start) begin
            n.pend = 1'b0;
        end
        if (wr) begin
            unique case (paddr_i)
                `STC_OFF_TXCTL: begin
                    // Empty flag is read-only
                    n.ctl = pwdata_i[7:0];
                    n.ctl[`STC_B_EMPTY] = 1'b0;
                end
                `STC_OFF_TXDATA: begin
                    n.hold = pwdata_i[7:0];
                    n.pend = 1'b1;
                end
                `STC_OFF_RXCTL: n.rxctl = pwdata_i[1:0];
                // Divisor may be retuned at run time; takes the next tick
                `STC_OFF_BAUD: n.div = pwdata_i[15:0];
                `STC_OFF_MASK: n.mask = pwdata_i[1:0];
                default: begin
                end
            endcase
        end
        // Hardware clears the break request once the break is sent
        if (lnk.done_brk) begin
            n.ctl[`STC_B_BREAK] = 1'b0;
        end
        // Sticky status: a new event beats a same-cycle clear
        n.stat = (s.stat & ~clr) | ev;
        n.irq = |(n.stat & n.mask);
        // Pin enables follow the new control values so they settle together
        // Data pin is released while sync reception owns it
        n.tx_oe = ~(n.ctl[`STC_B_SYNC]
            & (n.rxctl[`STC_B_RX_ONE] | n.rxctl[`STC_B_RX_CONT]));
        // Clock pin driven only as sync master with an effective enable
        n.sck_oe = n.ctl[`STC_B_SYNC] & n.ctl[`STC_B_CLKSRC]
            & n.ctl[`STC_B_TX_ON] & n.tx_oe;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s <= '{ctl: `STC_RST_TXCTL, hold: '0, pend: 1'b0,
                   rxctl: '0, div: `STC_RST_BAUD, stat: '0,
                   mask: `STC_RST_MASK, pready: 1'b0,
                   prdata: '0, pslverr: 1'b0, irq: 1'b0,
                   sck_q: 1'b0, tx_oe: 1'b1, sck_oe: 1'b0};
        end else begin
            s <= n;
        end
    end

    // Line outputs come from the shifter flops
    assign tx_o = sh_tx;
    assign sck_o = sh_sck;
    assign sck_oe_o = s.sck_oe;
    assign tx_oe_o = s.tx_oe;
    assign pready_o = s.pready;
    assign prdata_o = s.prdata;
    assign pslverr_o = s.pslverr;
    assign irq_o = s.irq;
endmodule
`default_nettype wire

// file: stc_monitor.sv
// Port checker for the transmit control block.
// Assumes it is bound to stc_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module stc_monitor (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic sck_o,
    input wire logic sck_oe_o,
    input wire logic tx_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // An access phase opens, then the answer follows one or two cycles on
    sequence s_access;
        $rose(psel_i && penable_i);
    endsequence
    sequence s_answer;
        ##[1:2] pready_o;
    endsequence

    chk_ready_wait: assert property (s_access |-> s_answer)
        else $error("answer late");
    chk_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready held");
    chk_ready_req: assert property (pready_o |-> psel_i && penable_i)
        else $error("ready without access");
    chk_err_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    // Outputs must leave reset idle: line high, no interrupt, no answer
    chk_reset_idle: assert property ($rose(rst_n_i)
        |-> tx_o && !irq_o && !pready_o)
        else $error("not idle after reset");
    // Fastest async bit is four clocks; sync master frames are excluded
    chk_start_width: assert property ($fell(tx_o) && !sck_oe_o
        |=> !tx_o [*3])
        else $error("start bit short");
    chk_sck_master: assert property ($rose(sck_o) |-> sck_oe_o)
        else $error("clock without drive");
    // The interrupt only drops after a register write
    chk_irq_clear: assert property ($fell(irq_o)
        |-> $past(pwrite_i && pready_o) || $past(pwrite_i && pready_o, 2)
        || $past(pwrite_i && pready_o, 3))
        else $error("irq fell alone");
endmodule

bind stc_top stc_monitor u_stc_monitor (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .sck_o(sck_o),
    .sck_oe_o(sck_oe_o), .tx_o(tx_o), .irq_o(irq_o));
`default_nettype wire

// file: stc_line_model.sv
// Remote serial receiver: samples the line mid-bit, keeps the last frame.
// Assumes async framing, LSB first, bit time given in clocks.
`timescale 1ns/1ps
`default_nettype none
module stc_line_model (
    input wire logic clk_i,
    input wire logic line_i,
    input wire logic nine_i,
    input wire logic [15:0] bit_clks_i,
    output logic sck_o,
    output logic [8:0] word_o,
    output logic stop_o,
    output int frames_o
);
    // This end never clocks the port, so its clock stands still
    assign sck_o = 1'b0;

    initial begin
        word_o = '0;
        stop_o = 1'b1;
        frames_o = 0;
    end

    // A start pulse shorter than half a bit is taken as noise
    always begin
        @(negedge line_i);
        repeat (bit_clks_i / 2) @(posedge clk_i);
        #1;
        if (line_i === 1'b0) begin
            for (int i = 0; i < 9; i++) begin
                word_o[i] = 1'b0;
                if (i < 8 || nine_i) begin
                    repeat (bit_clks_i) @(posedge clk_i);
                    #1;
                    word_o[i] = line_i;
                end
            end
            repeat (bit_clks_i) @(posedge clk_i);
            #1;
            stop_o = line_i;
            frames_o = frames_o + 1;
        end
    end
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the transmit control block.
// Assumes the checker binds itself to stc_top.
`timescale 1ns/1ps
`default_nettype none
`include "stc_cfg.svh"
module testbench;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic pready, pslverr, sck, sck_oe, tx, tx_oe, irq, sck_in, stop;
    logic [31:0] prdata;
    logic [8:0] word;
    logic nine = 1'b0;
    logic [15:0] bclk = 16'h0010;
    int frames;
    int fails = 0;
    int tests_run = 0;

    always #2.5 clk_i = ~clk_i;

    stc_top u_stc_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata),
        .pslverr_o(pslverr), .sck_i(sck_in), .sck_o(sck),
        .sck_oe_o(sck_oe), .tx_o(tx), .tx_oe_o(tx_oe), .irq_o(irq));
    stc_line_model u_stc_line_model (.clk_i(clk_i), .line_i(tx),
        .nine_i(nine), .bit_clks_i(bclk), .sck_o(sck_in), .word_o(word),
        .stop_o(stop), .frames_o(frames));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        @(posedge clk_i);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk_i);
        end
        if (pready !== 1'b1) fails++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        // Registered outputs show the written value one edge later
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask

    // Poll the control register until one bit reaches a value
    task automatic wait_ctl(input int b, input logic v);
        logic [31:0] r;
        int k;
        k = 0;
        rd(`STC_OFF_TXCTL, r);
        while (r[b] !== v && k < 400) begin
            k++;
            rd(`STC_OFF_TXCTL, r);
        end
        if (r[b] !== v) fails++;
    endtask

    task automatic t_regs();
        logic [31:0] r;
        logic e;
        rd(`STC_OFF_TXCTL, r);
        chk(r, 32'h00000002);
        wr(`STC_OFF_TXCTL, 32'h000000E5);
        rd(`STC_OFF_TXCTL, r);
        chk(r, 32'h000000E7);
        apb(1'b0, 8'h40, 32'h0, r, e);
        chk({r[30:0], e}, 32'h00000001);
        wr(`STC_OFF_TXCTL, 32'h00000000);
        $display("test regs done");
    endtask

    task automatic t_async8();
        logic [31:0] r;
        int n0;
        n0 = frames;
        wr(`STC_OFF_MASK, 32'h00000001);
        wr(`STC_OFF_TXCTL, 32'h00000020);
        wr(`STC_OFF_TXDATA, 32'h000000A5);
        rd(`STC_OFF_TXCTL, r);
        chk(r, 32'h00000020);
        wait_ctl(1, 1'b1);
        chk(frames, n0 + 1);
        chk({23'h0, word}, 32'h000000A5);
        chk({30'h0, stop, irq}, 32'h00000003);
        wr(`STC_OFF_MASK, 32'h00000000);
        chk({31'h0, irq}, 32'h00000000);
        wr(`STC_OFF_MASK, 32'h00000001);
        chk({31'h0, irq}, 32'h00000001);
        wr(`STC_OFF_STAT, 32'h00000001);
        rd(`STC_OFF_STAT, r);
        chk({r[30:0], irq}, 32'h00000000);
        $display("test async8 done");
    endtask

    task automatic t_async9();
        nine = 1'b1;
        bclk = 16'h0008;
        wr(`STC_OFF_BAUD, 32'h00000001);
        wr(`STC_OFF_TXCTL, 32'h00000065);
        wr(`STC_OFF_TXDATA, 32'h0000003C);
        wait_ctl(1, 1'b1);
        chk({22'h0, stop, word}, 32'h0000033C);
        $display("test async9 done");
    endtask

    task automatic t_break();
        logic [31:0] r;
        nine = 1'b0;
        bclk = 16'h0010;
        wr(`STC_OFF_BAUD, 32'h00000000);
        wr(`STC_OFF_TXCTL, 32'h00000028);
        wr(`STC_OFF_TXDATA, 32'h00000055);
        wait_ctl(3, 1'b0);
        chk({22'h0, stop, word}, 32'h00000000);
        rd(`STC_OFF_STAT, r);
        chk(r & 32'h00000002, 32'h00000002);
        wr(`STC_OFF_STAT, 32'h00000003);
        $display("test break done");
    endtask

    task automatic t_off();
        logic [31:0] r;
        int n0;
        n0 = frames;
        wr(`STC_OFF_TXCTL, 32'h00000000);
        wr(`STC_OFF_TXDATA, 32'h0000000F);
        repeat (200) @(posedge clk_i);
        rd(`STC_OFF_TXCTL, r);
        chk(r, 32'h00000002);
        chk(frames, n0);
        chk({31'h0, tx}, 32'h00000001);
        $display("test off done");
    endtask

    task automatic t_sync();
        wr(`STC_OFF_TXCTL, 32'h000000B0);
        wr(`STC_OFF_TXDATA, 32'h00000081);
        chk({30'h0, sck_oe, tx_oe}, 32'h00000003);
        wait_ctl(1, 1'b1);
        wr(`STC_OFF_RXCTL, 32'h00000002);
        chk({30'h0, sck_oe, tx_oe}, 32'h00000000);
        wr(`STC_OFF_TXCTL, 32'h000000A0);
        chk({30'h0, sck_oe, tx_oe}, 32'h00000001);
        wr(`STC_OFF_RXCTL, 32'h00000001);
        wr(`STC_OFF_TXCTL, 32'h00000030);
        chk({30'h0, sck_oe, tx_oe}, 32'h00000000);
        $display("test sync done");
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_async8();
        t_async9();
        t_break();
        t_off();
        t_sync();
        final_report();
    end

    // Whole run needs about a thousand cycles; this cuts a hang short
    initial begin
        repeat (40000) @(posedge clk_i);
        fails++;
        final_report();
    end
endmodule
`default_nettype wire
